// *** rtl/wake_enable_bank.sv ***
// wake-enable register bank with APB slave and wake output
module wake_enable_bank (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       main_reset_n,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]     prdata,
    output logic            pready,
    output logic            pslverr,
    input  wire logic       pin_3_0,
    input  wire logic       pin_3_1,
    input  wire logic       pin_3_2,
    input  wire logic       pin_3_3,
    input  wire logic       pin_4_1,
    input  wire logic       pin_4_3,
    input  wire logic       pin_6_0,
    input  wire logic       pin_6_1,
    input  wire logic       pin_5_0,
    input  wire logic       pin_5_1,
    input  wire logic       pin_5_2,
    input  wire logic       pin_5_3,
    input  wire logic       pin_5_4,
    input  wire logic       pin_5_5,
    input  wire logic       pin_5_6,
    input  wire logic       pin_5_7,
    output logic            wake_event_output_n_o,
    output logic            wake_event_output_n_oe,
    output logic            irq
);
    localparam int W = wake_enable_pkg::REG_W;

    // ****************************************
    // pin grouping and synchronisers
    // ****************************************
    logic [W-1:0] pins_a;
    logic [W-1:0] pins_b;

    // fixed bit order of the first group
    assign pins_a = {pin_6_1, pin_6_0, pin_4_3, pin_4_1,
                     pin_3_3, pin_3_2, pin_3_1, pin_3_0}; // R03
    // second group in plain ascending order
    assign pins_b = {pin_5_7, pin_5_6, pin_5_5, pin_5_4,
                     pin_5_3, pin_5_2, pin_5_1, pin_5_0}; // R04

    wake_src_if #(.W(W)) grp_a ();
    wake_src_if #(.W(W)) grp_b ();

    wake_pin_sync #(.W(W)) u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins_a),
        .src     (grp_a)
    );

    wake_pin_sync #(.W(W)) u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins_b),
        .src     (grp_b)
    );

    // ****************************************
    // main-supply reset synchroniser
    // ****************************************
    logic main_meta_r;
    logic main_sync_r;
    logic main_clr;

    // pin from another domain, two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_meta_r <= 1'b0;
            main_sync_r <= 1'b0;
        end
        else
        begin
            main_meta_r <= main_reset_n;
            main_sync_r <= main_meta_r;
        end
    end

    // low level clears global enable, status, irq status and mask, not the enables
    assign main_clr = !main_sync_r;

    // ****************************************
    // bus decode
    // ****************************************
    logic setup_ph;
    logic acc_ph;
    logic hit_ctrl;
    logic hit_sts_a;
    logic hit_sts_b;
    logic hit_irq_sts;
    logic hit_irq_msk;
    logic hit_en_a;
    logic hit_en_b;
    logic hit_rsvd;
    logic mapped;
    logic wr_acc;
    logic rd_acc;

    assign setup_ph = psel && !penable;
    assign acc_ph   = psel && penable;

    // full byte address compare, misaligned falls out
    assign hit_ctrl    = paddr == wake_enable_pkg::ADDR_GLOBAL_CTRL;
    assign hit_sts_a   = paddr == wake_enable_pkg::ADDR_STATUS_A;
    assign hit_sts_b   = paddr == wake_enable_pkg::ADDR_STATUS_B;
    assign hit_irq_sts = paddr == wake_enable_pkg::ADDR_IRQ_STATUS;
    assign hit_irq_msk = paddr == wake_enable_pkg::ADDR_IRQ_MASK;
    assign hit_en_a    = paddr == wake_enable_pkg::ADDR_ENABLE_A;
    assign hit_en_b    = paddr == wake_enable_pkg::ADDR_ENABLE_B;
    assign hit_rsvd    = paddr == wake_enable_pkg::ADDR_RESERVED;

    assign mapped = hit_ctrl | hit_sts_a | hit_sts_b | hit_irq_sts |
                    hit_irq_msk | hit_en_a | hit_en_b | hit_rsvd;

    // zero wait states, every access completes at once
    assign pready  = 1'b1;
    assign pslverr = acc_ph && !mapped;
    assign wr_acc  = acc_ph && pwrite && mapped;
    assign rd_acc  = acc_ph && !pwrite && mapped;

    // ****************************************
    // wake enable registers
    // ****************************************
    logic [W-1:0] enable_a_r;
    logic [W-1:0] enable_b_r;

    // only the standby reset reaches these flops;
    // main resets deliberately leave them alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_a_r <= wake_enable_pkg::RST_ENABLE; // R05
            enable_b_r <= wake_enable_pkg::RST_ENABLE; // R05
        end
        else
        begin
            if (wr_acc && hit_en_a)
            begin
                enable_a_r <= pwdata[W-1:0]; // R06
            end
            if (wr_acc && hit_en_b)
            begin
                enable_b_r <= pwdata[W-1:0]; // R06
            end
        end
    end

    // ****************************************
    // global wake enable
    // ****************************************
    logic global_wake_enable;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_wake_enable <= 1'b0;
        end
        else if (main_clr)
        begin
            global_wake_enable <= 1'b0;
        end
        else if (wr_acc && hit_ctrl)
        begin
            global_wake_enable <=
                pwdata[wake_enable_pkg::GLOBAL_EN_BIT];
        end
    end

    // ****************************************
    // wake status, sticky per source
    // ****************************************
    logic [W-1:0] status_a_r;
    logic [W-1:0] status_b_r;
    logic [W-1:0] clr_a;
    logic [W-1:0] clr_b;

    // write one to clear; a new edge beats the clear
    assign clr_a = (wr_acc && hit_sts_a) ? pwdata[W-1:0] : '0;
    assign clr_b = (wr_acc && hit_sts_b) ? pwdata[W-1:0] : '0;

    // status follows sources whatever the enables say
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_a_r <= wake_enable_pkg::RST_STATUS;
            status_b_r <= wake_enable_pkg::RST_STATUS;
        end
        else if (main_clr)
        begin
            status_a_r <= wake_enable_pkg::RST_STATUS;
            status_b_r <= wake_enable_pkg::RST_STATUS;
        end
        else
        begin
            status_a_r <= (status_a_r & ~clr_a) | grp_a.rise; // R02
            status_b_r <= (status_b_r & ~clr_b) | grp_b.rise; // R02
        end
    end

    // ****************************************
    // wake event output, open drain
    // ****************************************
    logic wake_nxt;
    logic wake_r;

    // a disabled source never reaches the output
    assign wake_nxt = global_wake_enable &&
                      (|(status_a_r & enable_a_r) ||
                       |(status_b_r & enable_b_r)); // R01 R02

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_r <= 1'b0;
        end
        else
        begin
            wake_r <= wake_nxt; // R01
        end
    end

    // pull low only; the line idles high by pull-up
    assign wake_event_output_n_o  = 1'b0;
    assign wake_event_output_n_oe = wake_r;

    // ****************************************
    // interrupt status and mask
    // ****************************************
    logic [wake_enable_pkg::IRQ_W-1:0] irq_sts_r;
    logic [wake_enable_pkg::IRQ_W-1:0] irq_msk_r;
    logic [wake_enable_pkg::IRQ_W-1:0] irq_set;
    logic                              irq_rd_clr;

    assign irq_set[wake_enable_pkg::IRQ_EVT_A_BIT] = |grp_a.rise;
    assign irq_set[wake_enable_pkg::IRQ_EVT_B_BIT] = |grp_b.rise;
    assign irq_set[wake_enable_pkg::IRQ_WAKE_BIT]  = wake_nxt && !wake_r;
    assign irq_rd_clr = rd_acc && hit_irq_sts;

    // read clears only the bits captured in setup, so an
    // event in the setup cycle is not lost; set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_sts_r <= wake_enable_pkg::RST_IRQ;
        end
        else if (main_clr)
        begin
            irq_sts_r <= wake_enable_pkg::RST_IRQ;
        end
        else if (irq_rd_clr)
        begin
            irq_sts_r <= (irq_sts_r &
                          ~prdata[wake_enable_pkg::IRQ_W-1:0]) |
                         irq_set;
        end
        else
        begin
            irq_sts_r <= irq_sts_r | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_msk_r <= wake_enable_pkg::RST_IRQ;
        end
        else if (main_clr)
        begin
            irq_msk_r <= wake_enable_pkg::RST_IRQ;
        end
        else if (wr_acc && hit_irq_msk)
        begin
            irq_msk_r <= pwdata[wake_enable_pkg::IRQ_W-1:0];
        end
    end

    // level output, one bit of mask per status bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_sts_r & irq_msk_r);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] rd_nxt;

    // sampled in setup so the access phase sees stable
    // data from a flop; a write to the reserved word
    // lands in no branch of any register above
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_nxt[wake_enable_pkg::GLOBAL_EN_BIT] = global_wake_enable;
        end
        else if (hit_sts_a)
        begin
            rd_nxt[W-1:0] = status_a_r;
        end
        else if (hit_sts_b)
        begin
            rd_nxt[W-1:0] = status_b_r;
        end
        else if (hit_irq_sts)
        begin
            rd_nxt[wake_enable_pkg::IRQ_W-1:0] = irq_sts_r;
        end
        else if (hit_irq_msk)
        begin
            rd_nxt[wake_enable_pkg::IRQ_W-1:0] = irq_msk_r;
        end
        else if (hit_en_a)
        begin
            rd_nxt[W-1:0] = enable_a_r; // R06
        end
        else if (hit_en_b)
        begin
            rd_nxt[W-1:0] = enable_b_r; // R06
        end
        else if (hit_rsvd)
        begin
            rd_nxt[W-1:0] = wake_enable_pkg::RST_RESERVED; // R07 R08
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_ph && !pwrite)
        begin
            prdata <= rd_nxt;
        end
    end

    // status read during its own setup: the value read
    // is the one cleared, later events stay pending
endmodule

// *** rtl/wake_enable_pkg.sv ***
// constants of the wake-enable register bank
//
// Function
// R01: drive wake only if enable, status, global set
// R02: enable clear: status still tracks, no drive
// R03: group a bits map pins 3_0..3_3,4_1,4_3,6_0,6_1
// R04: group b bits map pins 5_0..5_7
// R05: enables clear only on standby power-on reset
// R06: enable registers are eight-bit read/write
// R07: reserved location reads zero, read-only
// R08: writes to reserved location change nothing
package wake_enable_pkg;

    // ****************************************
    // register indices, byte address is index*4
    // ****************************************
    localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATUS_A    = 8'h01;
    localparam logic [7:0] IDX_STATUS_B    = 8'h02;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h03;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h04;
    localparam logic [7:0] IDX_ENABLE_A    = 8'h0d;
    localparam logic [7:0] IDX_ENABLE_B    = 8'h0e;
    localparam logic [7:0] IDX_RESERVED    = 8'h0f;

    localparam int         ADDR_W          = 8;
    localparam logic [7:0] ADDR_GLOBAL_CTRL = IDX_GLOBAL_CTRL << 2;
    localparam logic [7:0] ADDR_STATUS_A    = IDX_STATUS_A << 2;
    localparam logic [7:0] ADDR_STATUS_B    = IDX_STATUS_B << 2;
    localparam logic [7:0] ADDR_IRQ_STATUS  = IDX_IRQ_STATUS << 2;
    localparam logic [7:0] ADDR_IRQ_MASK    = IDX_IRQ_MASK << 2;
    localparam logic [7:0] ADDR_ENABLE_A    = IDX_ENABLE_A << 2;
    localparam logic [7:0] ADDR_ENABLE_B    = IDX_ENABLE_B << 2;
    localparam logic [7:0] ADDR_RESERVED    = IDX_RESERVED << 2;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         REG_W            = 8;
    localparam int         GLOBAL_EN_BIT    = 0;
    localparam int         IRQ_W            = 3;
    localparam int         IRQ_EVT_A_BIT    = 0;
    localparam int         IRQ_EVT_B_BIT    = 1;
    localparam int         IRQ_WAKE_BIT     = 2;
    localparam logic [7:0] RST_ENABLE       = 8'h00;
    localparam logic [7:0] RST_STATUS       = 8'h00;
    localparam logic [7:0] RST_RESERVED     = 8'h00;
    localparam logic [2:0] RST_IRQ          = 3'h0;

endpackage

// *** rtl/wake_pin_sync.sv ***
// two-flop synchroniser and rising-edge detect for wake pins
module wake_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pins,
    wake_src_if.src           src
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // first flop feeds only the second one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign src.level = sync_r;
    assign src.rise  = sync_r & ~prev_r;
endmodule

// *** rtl/wake_src_if.sv ***
// synchronised wake pin levels and rising-edge pulses
interface wake_src_if #(
    parameter int W = 8
);
    logic [W-1:0] level;
    logic [W-1:0] rise;

    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

// *** testbench/wake_bus_model.sv ***
// chipset wake input: open-drain line with a pull-up
module wake_bus_model (
    input  wire logic line_o,
    input  wire logic line_oe,
    output logic      wake_line,
    output int        wake_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins whenever nobody pulls the line
    assign wake_line = line_oe ? line_o : 1'b1;
    initial wake_count = 0;
    // count each wake assertion the chipset would see
    always @(negedge wake_line)
        wake_count++;
endmodule

// *** testbench/wake_enable_bank_bench.sv ***
// self-checking bench for the wake-enable register bank
module wake_enable_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        main_reset_n = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] pins = 16'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        line_o;
    logic        line_oe;
    logic        irq;
    logic        wake_line;
    int          wake_count;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          exp_count = 0;
    logic [31:0] q;
    logic        e;
    logic [7:0]  va;
    logic [7:0]  vb;
    logic        g;
    logic        en;

    always #2 pclk = ~pclk;

    wake_enable_bank dut_u (
        .pclk(pclk), .presetn(presetn), .main_reset_n(main_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_3_0(pins[0]), .pin_3_1(pins[1]),
        .pin_3_2(pins[2]), .pin_3_3(pins[3]), .pin_4_1(pins[4]),
        .pin_4_3(pins[5]), .pin_6_0(pins[6]), .pin_6_1(pins[7]),
        .pin_5_0(pins[8]), .pin_5_1(pins[9]), .pin_5_2(pins[10]),
        .pin_5_3(pins[11]), .pin_5_4(pins[12]), .pin_5_5(pins[13]),
        .pin_5_6(pins[14]), .pin_5_7(pins[15]),
        .wake_event_output_n_o(line_o), .wake_event_output_n_oe(line_oe),
        .irq(irq)
    );

    wake_bus_model far_u (
        .line_o(line_o), .line_oe(line_oe),
        .wake_line(wake_line), .wake_count(wake_count)
    );

    // ****************************************
    // expectations and bus tasks
    // ****************************************
    function automatic logic drives(logic gl, logic enb);
        return gl & enb;
    endfunction

    function automatic logic [7:0] st_addr(int i);
        return i < 8 ? 8'h04 : 8'h08;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; request held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(q, x);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        void'($urandom(80));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h34, 32'h0);
        rdchk(8'h38, 32'h0);
        $display("test reset values done");
        // random read-back, upper bits must be dropped
        for (int k = 0; k < 8; k++)
        begin
            va = k == 0 ? 8'hff : 8'($urandom);
            vb = k == 0 ? 8'h00 : 8'($urandom);
            wr(8'h34, {24'($urandom), va});
            wr(8'h38, {24'($urandom), vb});
            rdchk(8'h34, 32'(va));
            rdchk(8'h38, 32'(vb));
        end
        $display("test read-back done");
        // main-supply reset must leave enables alone
        main_reset_n <= 1'b0;
        repeat (6) @(posedge pclk);
        main_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(8'h34, 32'(va));
        rdchk(8'h38, 32'(vb));
        $display("test main reset done");
        wr(8'h3c, 32'hffffffff);
        chk(32'(e), 32'h0);
        rdchk(8'h3c, 32'h0);
        rdchk(8'h34, 32'(va));
        apb(8'h20, 1'b0, 32'h0);
        chk(32'(e), 32'h1);
        $display("test reserved done");
        wr(8'h10, 32'h7);
        // every pin, with global and enable varied
        for (int i = 0; i < 16; i++)
        begin
            g = (i % 3) != 2;
            en = (i % 4) != 3;
            wr(8'h00, 32'(g));
            wr(8'h34, i < 8 && en ? 32'h1 << i : 32'h0);
            wr(8'h38, i >= 8 && en ? 32'h1 << (i - 8) : 32'h0);
            pins[i] <= 1'b1;
            repeat (8) @(posedge pclk);
            chk(32'(wake_line), 32'(!drives(g, en)));
            rdchk(st_addr(i), 32'h1 << (i % 8));
            chk(32'(irq), 32'h1);
            pins[i] <= 1'b0;
            wr(st_addr(i), 32'hff);
            repeat (3) @(posedge pclk);
            chk(32'(wake_line), 32'h1);
            rdchk(8'h0c, {29'h0, drives(g, en), i >= 8, i < 8});
            repeat (2) @(posedge pclk);
            chk(32'(irq), 32'h0);
            exp_count += int'(drives(g, en));
        end
        chk(32'(wake_count), 32'(exp_count));
        $display("test wake pins done");
        // masked event must not raise the interrupt
        wr(8'h10, 32'h0);
        pins[8] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(irq), 32'h0);
        wr(8'h10, 32'h7);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        $display("test interrupt mask done");
        // main reset drops a driven line but keeps enables
        wr(8'h38, 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(wake_line), 32'h0);
        main_reset_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(wake_line), 32'h1);
        main_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(8'h08, 32'h0);
        rdchk(8'h38, 32'h1);
        // standby reset in mid-run clears the enables
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h38, 32'h0);
        rdchk(8'h34, 32'h0);
        $display("test resets done");
        finish_test();
    end

    // hang guard, far beyond the roughly 700 cycles used
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test();
    end
endmodule

// *** testbench/wake_enable_bank_checker.sv ***
// port assertions for the wake-enable register bank
module wake_enable_bank_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        main_reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wake_event_output_n_o,
    input wire logic        wake_event_output_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic mapped;
    // access phase and address decode
    assign acc = psel && penable;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                                  8'h34, 8'h38, 8'h3c};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // bus side
    // ****************************************
    AST_READY_ALWAYS: assert property (pready)
        else $error("pready low");
    AST_UPPER_ZERO: assert property (acc && !pwrite |->
        prdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_RSVD_READ: assert property (acc && !pwrite && paddr == 8'h3c
        |-> prdata == 32'h0 && !pslverr) else $error("reserved not zero");
    AST_RSVD_WRITE: assert property (acc && pwrite && paddr == 8'h3c
        |-> !pslverr) else $error("reserved write refused");
    AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped without error");
    AST_ERR_ACCESS: assert property (!acc |-> !pslverr)
        else $error("error outside access");

    // ****************************************
    // wake line
    // ****************************************
    AST_OD_DATA: assert property (!wake_event_output_n_o)
        else $error("open-drain data high");
    // clearing the global enable must release the line quickly
    AST_GLOBAL_OFF: assert property (acc && pwrite && paddr == 8'h00
        && !pwdata[0] |-> ##[1:2] !wake_event_output_n_oe)
        else $error("line held without global enable");
    AST_MAIN_RST: assert property (!main_reset_n [*5] |->
        !wake_event_output_n_oe) else $error("line held in main reset");
    AST_FIRST_EDGE: assert property ($rose(presetn) |->
        !wake_event_output_n_oe) else $error("line driven after reset");
endmodule

bind wake_enable_bank wake_enable_bank_checker chk_u (
    .pclk(pclk), .presetn(presetn), .main_reset_n(main_reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_event_output_n_o(wake_event_output_n_o),
    .wake_event_output_n_oe(wake_event_output_n_oe)
);
